// >>> verilog/nrh_pkg.sv
/*
  Package for the host-side controller of a byte-wide NV SRAM with a hidden calendar clock.
  Holds pin bundle, APB register map, command codes, key pattern and pin timing counts.
  Assumes a 250 MHz system clock.
*/
package nrh_pkg;

  // Pin bundle toward the memory socket
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [12:0] byte_select_lines;
    logic [7:0]  dq;
    logic        dq_oe_n;
  } nrh_pins_t;

  // Engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STRB  = 4'b0100,
    ST_RECOV = 4'b1000
  } nrh_state_t;

  // Sequence phase of a command
  typedef enum logic [1:0] {
    PH_RAM  = 2'h0,
    PH_ARM  = 2'h1,
    PH_KEY  = 2'h2,
    PH_XFER = 2'h3
  } nrh_phase_t;

  // Commands in CTRL[1:0]
  localparam logic [1:0] CMD_RAM_RD = 2'h0;
  localparam logic [1:0] CMD_RAM_WR = 2'h1;
  localparam logic [1:0] CMD_CLK_RD = 2'h2;
  localparam logic [1:0] CMD_CLK_WR = 2'h3;

  // APB register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_DATA    = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_SCRATCH = 8'h10;
  localparam logic [7:0] OFS_BUF     = 8'h20;
  localparam logic [7:0] OFS_BUF_END = 8'h3C;

  // Field positions
  localparam int CTRL_GO_BIT     = 4;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;

  // Reset values
  localparam logic [12:0] SCRATCH_RST = 13'h1FFF;
  localparam logic [12:0] ADDR_RST    = 13'h0000;
  localparam logic [7:0]  DATA_RST    = 8'h00;

  // Key C5,3A,A3,5C twice; bit i is the i-th bit sent
  localparam logic [63:0] KEY_PATTERN = 64'h5CA33AC5_5CA33AC5;
  localparam logic [5:0]  LAST_BIT    = 6'h3F;

  // Pin timing in ns and derived cycle counts (least times round up)
  localparam int CLK_NS     = 4;
  localparam int T_WP_NS    = 150;
  localparam int T_ACC_NS   = 200;
  localparam int T_WR_NS    = 20;
  localparam int T_OD_NS    = 100;
  localparam int SYNC_CYC   = 4;
  localparam logic [7:0] WP_CYC    = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RD_CYC    = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [7:0] WR_REC    = 8'((T_WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RD_REC    = 8'((T_OD_NS + CLK_NS - 1) / CLK_NS);

endpackage

// >>> verilog/nrh_buf_mem.sv
/*
  Eight-byte buffer holding the clock register image for one transfer.
  One write port, one read port with registered read data; single clock.
*/
`timescale 1ns/10ps
module nrh_buf_mem
  import nrh_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_we,
  input  wire logic [2:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [2:0] i_raddr,
  output logic      [7:0] o_rdata
);

  logic [7:0] mem_ff [0:7];
  logic [7:0] rdata_ff;

  // Storage, no reset: contents are meaningless until loaded
  always_ff @(posedge i_sys_clk)
  begin
    if (i_we)
    begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  // Registered read keeps the output timing clean
  always_ff @(posedge i_sys_clk)
  begin
    rdata_ff <= mem_ff[i_raddr];
  end

  assign o_rdata = rdata_ff;

endmodule // nrh_buf_mem

// >>> verilog/nrh_host.sv
/*
  Host controller that reaches the hidden calendar clock of a byte-wide NV SRAM
  through plain SRAM cycles, plus single RAM reads and writes, ordered over APB.
  Assumes one 250 MHz clock, an APB master, and the memory wired to o_sram/i_dq.
*/
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
module nrh_host
  import nrh_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output nrh_pins_t        o_sram,
  input  wire logic [7:0]  i_dq
);

  nrh_state_t  state_ff;
  nrh_phase_t  phase_ff;
  nrh_pins_t   pins_ff;
  logic [5:0]  idx_ff;
  logic [7:0]  cnt_ff;
  logic        cyc_wr_ff;
  logic        clk_wr_ff;
  logic [1:0]  cmd_ff;
  logic [12:0] addr_ff;
  logic [7:0]  wdata_ff;
  logic [7:0]  rdata_ff;
  logic [12:0] scratch_ff;
  logic        done_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  dq_s1_ff;
  logic [7:0]  dq_s2_ff;
  logic [7:0]  dq_s3_ff;
  logic [7:0]  dq_val_ff;
  logic [6:0]  shreg_ff;
  logic [7:0]  buf_rdata;
  logic        busy;
  logic        apb_acc;
  logic        go;
  logic        strobe_end;
  logic        capture;
  logic        buf_we;
  logic [2:0]  buf_waddr;
  logic [7:0]  buf_wdata;
  logic [2:0]  buf_raddr;
  logic [5:0]  idx_inc;

  // Key bit for a given stream position
  function automatic logic key_bit(input logic [5:0] idx);
    return KEY_PATTERN[idx];
  endfunction

  // Buffer window decode, used by both read and write paths
  function automatic logic in_buf(input logic [7:0] a);
    return (a >= OFS_BUF) && (a <= OFS_BUF_END) && (a[1:0] == 2'h0);
  endfunction

  assign busy       = (state_ff != ST_IDLE);
  assign apb_acc    = i_psel && i_penable && !pready_ff;
  assign go         = apb_acc && i_pwrite && (i_paddr == OFS_CTRL) && i_pwdata[CTRL_GO_BIT] && !busy;
  assign strobe_end = (state_ff == ST_STRB) && (cnt_ff == 8'h00);
  assign capture    = strobe_end && !cyc_wr_ff && (phase_ff == PH_XFER);

  // APB bus transaction: answer one cycle into the access phase
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= apb_acc;
      pslverr_ff <= 1'b0;
      if (apb_acc)
      begin
        prdata_ff <= 32'h0000_0000;
        if (!i_pwrite)
        begin
          case (i_paddr)
            OFS_CTRL:    prdata_ff <= {30'h0000_0000, cmd_ff};
            OFS_ADDR:    prdata_ff <= {19'h0_0000, addr_ff};
            OFS_DATA:    prdata_ff <= {24'h00_0000, rdata_ff};
            OFS_STATUS:  prdata_ff <= {30'h0000_0000, done_ff, busy};
            OFS_SCRATCH: prdata_ff <= {19'h0_0000, scratch_ff};
            default:
            begin
              if (in_buf(i_paddr))
              begin
                prdata_ff <= {24'h00_0000, buf_rdata};
              end
              else
              begin
                pslverr_ff <= 1'b1;
              end
            end
          endcase
        end
        else if (!(i_paddr inside {OFS_CTRL, OFS_ADDR, OFS_DATA, OFS_STATUS, OFS_SCRATCH}) && !in_buf(i_paddr))
        begin
          pslverr_ff <= 1'b1;
        end
      end
    end
  end

  // Software-written settings; ignored while a command runs
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cmd_ff     <= CMD_RAM_RD;
      addr_ff    <= ADDR_RST;
      wdata_ff   <= DATA_RST;
      scratch_ff <= SCRATCH_RST;
    end
    else if (apb_acc && i_pwrite && !busy)
    begin
      case (i_paddr)
        OFS_CTRL:    cmd_ff     <= i_pwdata[1:0];
        OFS_ADDR:    addr_ff    <= i_pwdata[12:0];
        OFS_DATA:    wdata_ff   <= i_pwdata[7:0];
        OFS_SCRATCH: scratch_ff <= i_pwdata[12:0];
        default:     cmd_ff     <= cmd_ff;
      endcase
    end
  end

  // Done flag: completion wins over a write-one clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      done_ff <= 1'b0;
    end
    else if (state_ff == ST_RECOV && cnt_ff == 8'h00 && (phase_ff == PH_RAM || (phase_ff == PH_XFER && idx_ff == LAST_BIT)))
    begin
      done_ff <= 1'b1;
    end
    else if (apb_acc && i_pwrite && i_paddr == OFS_STATUS && i_pwdata[STAT_DONE_BIT])
    begin
      done_ff <= 1'b0;
    end
  end

  // Data pins come from outside the clock domain: three flops, accept on agreement
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      dq_s1_ff  <= 8'h00;
      dq_s2_ff  <= 8'h00;
      dq_s3_ff  <= 8'h00;
      dq_val_ff <= 8'h00;
    end
    else
    begin
      dq_s1_ff <= i_dq;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
      for (int b = 0; b < 8; b++)
      begin
        if (dq_s2_ff[b] == dq_s3_ff[b])
        begin
          dq_val_ff[b] <= dq_s3_ff[b];
        end
      end
    end
  end

  // Read results: RAM byte, or clock bits gathered LSB first
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rdata_ff <= DATA_RST;
      shreg_ff <= 7'h00;
    end
    else if (strobe_end && !cyc_wr_ff && phase_ff == PH_RAM)
    begin
      rdata_ff <= dq_val_ff;
    end
    else if (capture)
    begin
      shreg_ff[idx_ff[2:0]] <= dq_val_ff[0];
    end
  end

  // Buffer ports: engine owns them while busy, APB otherwise
  assign buf_we    = busy ? (capture && idx_ff[2:0] == 3'h7)
                          : (apb_acc && i_pwrite && in_buf(i_paddr));
  assign buf_waddr = busy ? idx_ff[5:3] : i_paddr[4:2];
  assign buf_wdata = busy ? {dq_val_ff[0], shreg_ff} : i_pwdata[7:0];
  // Registered read port: fetch the next bit's byte at the last recovery edge,
  // otherwise a write transfer would send stale data at every byte boundary
  assign idx_inc   = idx_ff + 6'h01;
  assign buf_raddr = !busy ? i_paddr[4:2]
                   : ((state_ff == ST_RECOV && cnt_ff == 8'h00) ? idx_inc[5:3] : idx_ff[5:3]);

  nrh_buf_mem u_buf (
    .i_sys_clk (i_sys_clk),
    .i_we      (buf_we),
    .i_waddr   (buf_waddr),
    .i_wdata   (buf_wdata),
    .i_raddr   (buf_raddr),
    .o_rdata   (buf_rdata)
  );

  // Pin cycle engine: setup, strobe, recovery; sequence across phases
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_ff  <= ST_IDLE;
      phase_ff  <= PH_RAM;
      idx_ff    <= 6'h00;
      cnt_ff    <= 8'h00;
      cyc_wr_ff <= 1'b0;
      clk_wr_ff <= 1'b0;
      pins_ff   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, byte_select_lines: 13'h0000, dq: 8'h00, dq_oe_n: 1'b1};
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (go)
          begin
            state_ff  <= ST_SETUP;
            idx_ff    <= 6'h00;
            clk_wr_ff <= (cmd_ff == CMD_CLK_WR);
            if (cmd_ff == CMD_RAM_RD || cmd_ff == CMD_RAM_WR)
            begin
              phase_ff  <= PH_RAM;
              cyc_wr_ff <= (cmd_ff == CMD_RAM_WR);
              pins_ff.byte_select_lines <= addr_ff;
            end
            else
            begin
              phase_ff  <= PH_ARM;
              cyc_wr_ff <= 1'b0;
              pins_ff.byte_select_lines <= scratch_ff;
            end
          end
        end
        ST_SETUP:
        begin
          // Address settles a cycle before any strobe; write data and its drive enable change on the same edge as the strobes
          state_ff        <= ST_STRB;
          pins_ff.ce_n    <= 1'b0;
          pins_ff.we_n    <= !cyc_wr_ff;
          pins_ff.oe_n    <= cyc_wr_ff;
          pins_ff.dq_oe_n <= !cyc_wr_ff;
          cnt_ff          <= (cyc_wr_ff ? WP_CYC : RD_CYC) - 8'h01;
          case (phase_ff)
            PH_KEY:  pins_ff.dq <= {7'h00, key_bit(idx_ff)};
            PH_XFER: pins_ff.dq <= {7'h00, buf_rdata[idx_ff[2:0]]};
            default: pins_ff.dq <= wdata_ff;
          endcase
        end
        ST_STRB:
        begin
          // Address stays put until the strobes are back high
          if (cnt_ff == 8'h00)
          begin
            state_ff     <= ST_RECOV;
            pins_ff.ce_n <= 1'b1;
            pins_ff.we_n <= 1'b1;
            pins_ff.oe_n <= 1'b1;
            cnt_ff       <= cyc_wr_ff ? WR_REC : RD_REC;
          end
          else
          begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ST_RECOV:
        begin
          // Data held through recovery for write hold time
          if (cnt_ff == 8'h00)
          begin
            pins_ff.dq_oe_n <= 1'b1;
            state_ff        <= ST_SETUP;
            case (phase_ff)
              PH_ARM:
              begin
                phase_ff  <= PH_KEY;
                cyc_wr_ff <= 1'b1;
              end
              PH_KEY:
              begin
                if (idx_ff == LAST_BIT)
                begin
                  phase_ff  <= PH_XFER;
                  cyc_wr_ff <= clk_wr_ff;
                end
                idx_ff <= idx_ff + 6'h01;
              end
              PH_XFER:
              begin
                idx_ff <= idx_ff + 6'h01;
                if (idx_ff == LAST_BIT)
                begin
                  state_ff <= ST_IDLE;
                end
              end
              default: state_ff <= ST_IDLE;
            endcase
          end
          else
          begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign o_prdata  = prdata_ff;
  assign o_pready  = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_sram    = pins_ff;

endmodule // nrh_host

// >>> tb/nrh_host_assertions.sv
/*
  Checker for the host controller: APB timing and the SRAM strobe shape.
  Assumes a bind to nrh_host and sees only its ports.
*/
`timescale 1ns/10ps
module nrh_host_assertions
  import nrh_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic       o_pready,
  input wire logic       o_pslverr,
  input wire nrh_pins_t  o_sram
);
  logic [7:0] lo_cnt_ff;
  logic       mapped;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // Chip-select low time, cleared once it rises
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      lo_cnt_ff <= 8'h00;
    else
      lo_cnt_ff <= o_sram.ce_n ? 8'h00 : lo_cnt_ff + 8'h01;
  end

  // Offsets backed by a register
  assign mapped = i_paddr <= OFS_SCRATCH || (i_paddr >= OFS_BUF && i_paddr <= OFS_BUF_END);

  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_wait; i_psel && i_penable && !o_pready; endsequence
  sequence s_wr_on; !o_sram.ce_n && !o_sram.we_n; endsequence

  property p_one_wait; s_setup ##1 s_wait |=> o_pready; endproperty
  property p_one_pulse; o_pready |=> !o_pready; endproperty
  property p_err_map; o_pready && i_paddr[1:0] == 2'h0 |-> o_pslverr == !mapped; endproperty
  property p_addr_hold; s_wr_on ##1 s_wr_on |-> $stable(o_sram.byte_select_lines); endproperty
  property p_oe_off_wr; !o_sram.we_n |-> o_sram.oe_n; endproperty
  property p_rd_form; !o_sram.oe_n |-> o_sram.dq_oe_n && !o_sram.ce_n && o_sram.we_n; endproperty
  property p_strobe_len; $rose(o_sram.ce_n) |-> lo_cnt_ff == ($past(o_sram.we_n) ? 8'h36 : 8'h26); endproperty
  property p_wr_data; $rose(o_sram.we_n) |-> !o_sram.dq_oe_n && $stable(o_sram.dq); endproperty

  a_one_wait: assert property (p_one_wait) else $error("pready not after one wait state");
  a_one_pulse: assert property (p_one_pulse) else $error("pready longer than one cycle");
  a_err_map: assert property (p_err_map) else $error("pslverr disagrees with the map");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved during a write");
  a_oe_off_wr: assert property (p_oe_off_wr) else $error("output gate low during a write");
  a_rd_form: assert property (p_rd_form) else $error("bad read strobe set");
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width off");
  a_wr_data: assert property (p_wr_data) else $error("data not held at write end");
endmodule // nrh_host_assertions

// >>> tb/nrh_dev_model.sv
/*
  Behavioural model of the NV SRAM with the hidden serial clock.
  Assumes the bench resolves the data wire from o_dq_en.
*/
`timescale 1ns/10ps
module nrh_dev_model
  import nrh_pkg::*;
#(
  parameter logic [63:0] CLK_INIT = 64'h0
)
(
  input  wire nrh_pins_t i_pins,
  output logic [7:0]     o_dq,
  output logic           o_dq_en
);
  localparam logic [63:0] MKEY = {2{32'h5CA33AC5}};
  logic [7:0]  ram [8192];
  logic [63:0] regs = CLK_INIT;
  logic [63:0] shadow;
  logic [6:0]  ptr  = 7'h00;
  logic [6:0]  cnt  = 7'h00;
  logic        dead = 1'b1;
  logic        xfer = 1'b0;
  logic        supply_fail = 1'b0; // Supply stays good in these tests
  wire         rd_act = !supply_fail && !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n;
  wire         wr_act = !supply_fail && !i_pins.ce_n && !i_pins.we_n;

  // Drive only while a read is open, so WE low drops it at once
  assign o_dq_en = rd_act;

  // One step of the transfer; a write run loads all at its end
  task automatic step(input logic wr);
    cnt = cnt + 7'h01;
    if (cnt == 7'h40)
    begin
      xfer = 1'b0;
      if (wr)
        regs = shadow;
    end
  endtask

  // Read start: clock bit in transfer, else RAM byte and key restart
  always @(posedge rd_act)
  begin
    if (xfer)
    begin
      o_dq = {7'h00, regs[cnt[5:0]]};
      step(1'b0);
    end
    else
    begin
      o_dq = ram[i_pins.byte_select_lines];
      ptr  = 7'h00;
      dead = 1'b0;
    end
  end

  // Write ends on the first strobe rise
  always @(negedge wr_act)
  begin
    if (xfer)
    begin
      shadow[cnt[5:0]] = i_pins.dq[0];
      step(1'b1);
    end
    else
    begin
      ram[i_pins.byte_select_lines] = i_pins.dq;
      if (!dead && i_pins.dq[0] == MKEY[ptr[5:0]])
        ptr = ptr + 7'h01;
      else
        dead = 1'b1;
      if (ptr == 7'h40)
      begin
        xfer = 1'b1;
        cnt  = 7'h00;
        dead = 1'b1;
      end
    end
  end
endmodule // nrh_dev_model

// >>> tb/nrh_host_test.sv
/*
  Self-checking bench for the host controller with the device model on its pins.
  Assumes the one-wait-state APB slave and the register offsets of the package.
*/
`timescale 1ns/10ps
`define CHK(nm, e, s) \
  begin n_checks++; if ((s) !== (e)) \
  begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module nrh_host_test;
  import nrh_pkg::*;
  // Oscillator off, abort pin ignored, 24-hour mode, valid month-end date, all fields BCD
  localparam logic [63:0] INIT = 64'h9912313723595842;
  localparam logic [33:0] W    = 34'h0;
  localparam logic [33:0] SKIP = 34'h200000000;
  logic        sys_clk  = 1'b0;
  logic        rstn     = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [7:0]  flt      = 8'h00;
  logic [12:0] cur_addr = 13'h0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, m_en;
  logic [7:0]  dq_in, m_dq, b;
  logic [33:0] note;
  logic [63:0] nv;
  logic [33:0] notes[$];
  nrh_pins_t   sram;
  int          n_fail   = 0;
  int          n_checks = 0;

  always #2 sys_clk = ~sys_clk;

  // Data wire: host, else device, else a pattern that never rests
  assign dq_in = !sram.dq_oe_n ? sram.dq : (m_en ? m_dq : flt);

  nrh_host dut_u (
    .i_sys_clk (sys_clk),
    .i_rstn    (rstn),
    .i_psel    (psel),
    .i_penable (penable),
    .i_pwrite  (pwrite),
    .i_paddr   (paddr),
    .i_pwdata  (pwdata),
    .o_prdata  (prdata),
    .o_pready  (pready),
    .o_pslverr (pslverr),
    .o_sram    (sram),
    .i_dq      (dq_in)
  );

  nrh_dev_model #(.CLK_INIT(INIT)) mdl_u (
    .i_pins  (sram),
    .o_dq    (m_dq),
    .o_dq_en (m_en)
  );

  // Watcher: each APB answer against the oldest note, unless that note is marked skip
  always @(posedge sys_clk)
  begin
    flt <= flt + 8'h35;
    if (sram.dq_oe_n === 1'b0)
      `CHK("dq_clash", 1'b0, m_en)
    if (pready === 1'b1)
    begin
      note = notes.pop_front();
      if (!note[33])
        `CHK("apb", note[32:0], {pslverr, pwrite ? 32'h0 : prdata})
    end
  end

  // One APB transfer; the note is {skip, error, data}
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [33:0] n);
    notes.push_back(n);
    @(posedge sys_clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Command with a refused ADDR write while busy, then wait for done
  task automatic run(input logic [1:0] c);
    apb(OFS_CTRL, 1'b1, {30'h0, c}, W);
    apb(OFS_CTRL, 1'b1, {27'h0, 1'b1, 2'h0, c}, W);
    apb(OFS_ADDR, 1'b1, {19'h0, ~cur_addr}, W);
    rd = 32'h0;
    while (rd[STAT_DONE_BIT] !== 1'b1)
      apb(OFS_STATUS, 1'b0, 32'h0, SKIP);
    apb(OFS_STATUS, 1'b1, 32'h2, W);
    apb(OFS_ADDR, 1'b0, 32'h0, {21'h0, cur_addr});
  endtask

  task automatic chk_buf(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      apb(OFS_BUF + 8'(4 * i), 1'b0, 32'h0, {26'h0, v[8 * i +: 8]});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h260774F3));
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(OFS_SCRATCH, 1'b0, 32'h0, {21'h0, SCRATCH_RST});
    apb(OFS_ADDR, 1'b0, 32'h0, {21'h0, ADDR_RST});
    apb(8'h40, 1'b1, 32'h0, 34'h100000000);
    repeat (3)
    begin
      cur_addr = 13'($urandom_range(32'h1FFE));
      b = 8'($urandom);
      apb(OFS_ADDR, 1'b1, {19'h0, cur_addr}, W);
      apb(OFS_DATA, 1'b1, {24'h0, b}, W);
      run(CMD_RAM_WR);
      `CHK("ram_cell", b, mdl_u.ram[cur_addr])
      run(CMD_RAM_RD);
      apb(OFS_DATA, 1'b0, 32'h0, {26'h0, b});
    end
    run(CMD_CLK_RD);
    chk_buf(INIT);
    `CHK("scratch", 8'h00, mdl_u.ram[SCRATCH_RST])
    for (int i = 0; i < 8; i++)
    begin
      nv[8 * i +: 8] = {4'($urandom_range(9)), 4'($urandom_range(9))};
      apb(OFS_BUF + 8'(4 * i), 1'b1, {24'h0, nv[8 * i +: 8]}, W);
    end
    run(CMD_CLK_WR);
    `CHK("clock_regs", nv, mdl_u.regs)
    run(CMD_CLK_RD);
    chk_buf(nv);
    conclude();
  end

  // Watchdog well past the expected length
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule // nrh_host_test

bind nrh_host nrh_host_assertions chk_u (
  .i_sys_clk (i_sys_clk),
  .i_rstn    (i_rstn),
  .i_psel    (i_psel),
  .i_penable (i_penable),
  .i_paddr   (i_paddr),
  .o_pready  (o_pready),
  .o_pslverr (o_pslverr),
  .o_sram    (o_sram)
);
